// *** inc/cssq_pkg.sv ***
package cssq_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OPTIONS_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET  = 8'h04;
	localparam logic [7:0] PHASE_OFFSET   = 8'h08;

	// ----------------------------------------------------------------
	// Option register field positions
	// ----------------------------------------------------------------
	localparam int DONE_PHASE_LSB      = 0;
	localparam int TRISTATE_PHASE_LSB  = 4;
	localparam int WRITE_PHASE_LSB     = 8;
	localparam int LOCK_PHASE_LSB      = 12;
	localparam int MATCH_PHASE_LSB     = 16;
	localparam int DONE_PIPE_BIT       = 20;
	localparam int ACTIVE_RECONFIG_BIT = 21;
	localparam int PORT_SELECT_LSB     = 22;
	localparam int SECURITY_LSB        = 24;
	localparam int ERROR_SIGNAL_BIT    = 26;

	// ----------------------------------------------------------------
	// Phase codes and option encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] PHASE_AT_DONE   = 3'h0;
	localparam logic [2:0] PHASE_KEEP      = 3'h7;
	localparam logic [2:0] NO_WAIT_SETTING = 3'h7;
	localparam logic [2:0] LAST_PHASE      = 3'h7;
	localparam logic [1:0] PORT_AUTO       = 2'h0;
	localparam logic [1:0] PORT_UPPER      = 2'h1;
	localparam logic [1:0] PORT_LOWER      = 2'h2;
	localparam logic [1:0] SECURITY_NONE   = 2'h0;
	localparam logic [1:0] SECURITY_LEVEL1 = 2'h1;
	localparam logic [1:0] SECURITY_LEVEL2 = 2'h2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] DONE_PHASE_RST     = 3'h4;
	localparam logic [2:0] TRISTATE_PHASE_RST = 3'h5;
	localparam logic [2:0] WRITE_PHASE_RST    = 3'h6;
	localparam logic [2:0] LOCK_PHASE_RST     = 3'h7;
	localparam logic [2:0] MATCH_PHASE_RST    = 3'h7;
	localparam logic       DONE_PIPE_RST      = 1'b0;
	localparam logic       ACTIVE_RECONF_RST  = 1'b0;
	localparam logic [1:0] PORT_SELECT_RST    = 2'h0;
	localparam logic [1:0] SECURITY_RST       = 2'h0;
	localparam logic       ERROR_SIGNAL_RST   = 1'b1;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CSSQ_IDLE = 3'b001,
		CSSQ_RUN  = 3'b010,
		CSSQ_END  = 3'b100
	} cssq_state_t;

endpackage

// *** logic/cssq_sequencer.sv ***
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// RL1: Configuration and readback traffic go through the upper or lower access port per the select option, automatic by default.
// RL2: With active reconfiguration set, neither the interconnect hold nor the global set/reset is asserted during configuration.
// RL3: Security None allows readback, Level1 disables it, and Level2 is treated here as disabling it too.
// RL4: Done is raised in a selectable phase 1 to 6 or never (Keep), default phase 4.
// RL5: With done pipelining set, done rises one configuration clock tick after its selected phase.
// RL6: The output tristate is released in phase 1 to 6, at done, or never, default phase 5.
// RL7: The global write enable and block RAM enable assert in phase 1 to 6, at done, or never, default 6.
// RL8: Block RAM reads and writes stay disabled until the write enable phase.
// RL9: A lock wait phase 0 to 6 holds the sequence there until every clock manager reports lock.
// RL10: With the no-wait lock setting the sequence ignores lock status.
// RL11: A match phase 0 to 6 stalls the sequence there until impedance calibration has matched.
// RL12: Calibration runs before the match phase; the sequencer only waits, so startup length varies.
// RL13: The external source keeps toggling the configuration clock until done goes high.
// RL14: The auto match setting is resolved by the generator to phase 2 or no wait before load.
// RL15: With error signalling enabled, a configuration error drives the active low init pin to 0.
// RL16: The sequence steps one phase per rising configuration clock edge from phase 0, except while waiting.
module cssq_sequencer (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        config_clk,
	input  wire logic        clock_manager_locked,
	input  wire logic        impedance_calibration_match,
	input  wire logic        load_done,
	input  wire logic        config_error,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	output logic             done_out,
	output logic             global_output_tristate,
	output logic             global_write_enable,
	output logic             bram_enable,
	output logic             global_interconnect_hold,
	output logic             global_set_reset,
	output logic             port_upper_enable,
	output logic             port_lower_enable,
	output logic             readback_enable,
	output logic             init_status_n
);

	// ----------------------------------------------------------------
	// Synchronisers for the pin side inputs
	// ----------------------------------------------------------------
	logic [1:0] clk_sync_r;
	logic [1:0] lock_sync_r;
	logic [1:0] match_sync_r;
	logic       clk_prev_r;
	logic       tick;

	// Only the second stage of each chain is looked at by any logic.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_sync_r   <= 2'b00;
			lock_sync_r  <= 2'b00;
			match_sync_r <= 2'b00;
			clk_prev_r   <= 1'b0;
		end else begin
			clk_sync_r   <= {clk_sync_r[0], config_clk};
			lock_sync_r  <= {lock_sync_r[0], clock_manager_locked};
			match_sync_r <= {match_sync_r[0], impedance_calibration_match};
			clk_prev_r   <= clk_sync_r[1];
		end
	end

	// One tick per rising configuration clock edge; the clock must be slower than half core_clk.
	assign tick = clk_sync_r[1] & ~clk_prev_r;

	// ----------------------------------------------------------------
	// Option register
	// ----------------------------------------------------------------
	logic [2:0] done_phase_r;
	logic [2:0] tristate_phase_r;
	logic [2:0] write_phase_r;
	logic [2:0] lock_phase_r;
	logic [2:0] match_phase_r;
	logic       done_pipelining_r;
	logic       active_reconfig_option_r;
	logic [1:0] config_port_select_r;
	logic [1:0] security_r;
	logic       error_signal_r;

	// Options are meant to be written before load; a change mid-sequence takes effect at once.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_phase_r             <= cssq_pkg::DONE_PHASE_RST;
			tristate_phase_r         <= cssq_pkg::TRISTATE_PHASE_RST;
			write_phase_r            <= cssq_pkg::WRITE_PHASE_RST;
			lock_phase_r             <= cssq_pkg::LOCK_PHASE_RST;
			match_phase_r            <= cssq_pkg::MATCH_PHASE_RST;
			done_pipelining_r        <= cssq_pkg::DONE_PIPE_RST;
			active_reconfig_option_r <= cssq_pkg::ACTIVE_RECONF_RST;
			config_port_select_r     <= cssq_pkg::PORT_SELECT_RST;
			security_r               <= cssq_pkg::SECURITY_RST;
			error_signal_r           <= cssq_pkg::ERROR_SIGNAL_RST;
		end else if (reg_write && reg_addr == cssq_pkg::OPTIONS_OFFSET) begin
			done_phase_r             <= reg_wdata[cssq_pkg::DONE_PHASE_LSB +: 3];
			tristate_phase_r         <= reg_wdata[cssq_pkg::TRISTATE_PHASE_LSB +: 3];
			write_phase_r            <= reg_wdata[cssq_pkg::WRITE_PHASE_LSB +: 3];
			lock_phase_r             <= reg_wdata[cssq_pkg::LOCK_PHASE_LSB +: 3];
			match_phase_r            <= reg_wdata[cssq_pkg::MATCH_PHASE_LSB +: 3];
			done_pipelining_r        <= reg_wdata[cssq_pkg::DONE_PIPE_BIT];
			active_reconfig_option_r <= reg_wdata[cssq_pkg::ACTIVE_RECONFIG_BIT];
			config_port_select_r     <= reg_wdata[cssq_pkg::PORT_SELECT_LSB +: 2];
			security_r               <= reg_wdata[cssq_pkg::SECURITY_LSB +: 2];
			error_signal_r           <= reg_wdata[cssq_pkg::ERROR_SIGNAL_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Phase sequencer
	// ----------------------------------------------------------------
	cssq_pkg::cssq_state_t state_r;
	logic [2:0]            phase_r;
	logic                  lock_hold;
	logic                  match_hold;
	logic                  step_ok;

	// Wait codes of 7 mean no wait, since phase 7 is never a wait slot.
	assign lock_hold  = (lock_phase_r != cssq_pkg::NO_WAIT_SETTING) &&
	                    (phase_r == lock_phase_r) && !lock_sync_r[1]; // RL9 RL10
	// Calibration is started elsewhere before this phase; here it is only awaited.
	assign match_hold = (match_phase_r != cssq_pkg::NO_WAIT_SETTING) &&
	                    (phase_r == match_phase_r) && !match_sync_r[1]; // RL11 RL12
	assign step_ok    = tick && !lock_hold && !match_hold;

	// Runs once per load; dropping load_done returns to idle for a new configuration.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= cssq_pkg::CSSQ_IDLE;
			phase_r <= 3'h0;
		end else begin
			case (state_r)
				cssq_pkg::CSSQ_IDLE: begin
					phase_r <= 3'h0;
					if (load_done) begin
						state_r <= cssq_pkg::CSSQ_RUN;
					end
				end
				cssq_pkg::CSSQ_RUN: begin
					if (!load_done) begin
						state_r <= cssq_pkg::CSSQ_IDLE;
					end else if (step_ok) begin
						if (phase_r == cssq_pkg::LAST_PHASE) begin
							state_r <= cssq_pkg::CSSQ_END;
						end else begin
							phase_r <= phase_r + 3'h1; // RL16
						end
					end
				end
				cssq_pkg::CSSQ_END: begin
					if (!load_done) begin
						state_r <= cssq_pkg::CSSQ_IDLE;
					end
				end
				default: begin
					state_r <= cssq_pkg::CSSQ_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Startup events
	// ----------------------------------------------------------------
	logic running;
	logic done_hit;
	logic done_pend_r;
	logic done_r;
	logic done_evt;
	logic tristate_r;
	logic write_en_r;

	assign running  = (state_r == cssq_pkg::CSSQ_RUN) && tick;
	assign done_hit = running && (done_phase_r != cssq_pkg::PHASE_KEEP) &&
	                  (done_phase_r != cssq_pkg::PHASE_AT_DONE) && (phase_r == done_phase_r);
	assign done_evt = !done_r && ((done_hit && !done_pipelining_r) || (done_pend_r && tick));

	// Done rises in its phase, or one tick later when pipelined.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_r      <= 1'b0;
			done_pend_r <= 1'b0;
		end else if (state_r == cssq_pkg::CSSQ_IDLE) begin
			done_r      <= 1'b0;
			done_pend_r <= 1'b0;
		end else begin
			if (done_hit && done_pipelining_r && !done_r) begin
				done_pend_r <= 1'b1; // RL5
			end else if (done_pend_r && tick) begin
				done_pend_r <= 1'b0;
			end
			if (done_evt) begin
				done_r <= 1'b1; // RL4 RL5
			end
		end
	end

	// Tristate stays asserted until its phase or the done event; Keep never releases.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tristate_r <= 1'b1;
		end else if (state_r == cssq_pkg::CSSQ_IDLE) begin
			tristate_r <= 1'b1;
		end else if (tristate_phase_r == cssq_pkg::PHASE_AT_DONE) begin
			if (done_evt) begin
				tristate_r <= 1'b0; // RL6
			end
		end else if (tristate_phase_r != cssq_pkg::PHASE_KEEP && running &&
		             phase_r == tristate_phase_r) begin
			tristate_r <= 1'b0; // RL6
		end
	end

	// Write enable also gates block RAM access, so RAMs are idle until this fires.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			write_en_r <= 1'b0;
		end else if (state_r == cssq_pkg::CSSQ_IDLE) begin
			write_en_r <= 1'b0;
		end else if (write_phase_r == cssq_pkg::PHASE_AT_DONE) begin
			if (done_evt) begin
				write_en_r <= 1'b1; // RL7 RL8
			end
		end else if (write_phase_r != cssq_pkg::PHASE_KEEP && running &&
		             phase_r == write_phase_r) begin
			write_en_r <= 1'b1; // RL7 RL8
		end
	end

	// ----------------------------------------------------------------
	// Error latch
	// ----------------------------------------------------------------
	logic error_r;

	// Sticky until a new load starts; an error in that same cycle still sets it.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			error_r <= 1'b0;
		end else if (config_error) begin
			error_r <= 1'b1;
		end else if (state_r == cssq_pkg::CSSQ_IDLE && load_done) begin
			error_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	logic in_config;

	assign in_config = (state_r == cssq_pkg::CSSQ_IDLE);

	// Every top output is a flop, which costs one core cycle behind the internal state.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_out                 <= 1'b0;
			global_output_tristate   <= 1'b1;
			global_write_enable      <= 1'b0;
			bram_enable              <= 1'b0;
			global_interconnect_hold <= 1'b0;
			global_set_reset         <= 1'b0;
			init_status_n            <= 1'b1;
		end else begin
			done_out                 <= done_r;
			global_output_tristate   <= tristate_r;
			global_write_enable      <= write_en_r; // RL7
			bram_enable              <= write_en_r; // RL8
			global_interconnect_hold <= in_config && !active_reconfig_option_r; // RL2
			global_set_reset         <= in_config && !active_reconfig_option_r; // RL2
			init_status_n            <= !(error_r && error_signal_r); // RL15
		end
	end

	// Port choice and readback permission follow the options directly.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_upper_enable <= 1'b0;
			port_lower_enable <= 1'b0;
			readback_enable   <= 1'b0;
		end else begin
			port_upper_enable <= (config_port_select_r == cssq_pkg::PORT_UPPER) ||
			                     (config_port_select_r == cssq_pkg::PORT_AUTO); // RL1
			port_lower_enable <= (config_port_select_r == cssq_pkg::PORT_LOWER); // RL1
			readback_enable   <= (security_r == cssq_pkg::SECURITY_NONE); // RL3
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;

	// Unmapped addresses read as zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (reg_addr)
			cssq_pkg::OPTIONS_OFFSET: begin
				rd_mux[cssq_pkg::DONE_PHASE_LSB +: 3]     = done_phase_r;
				rd_mux[cssq_pkg::TRISTATE_PHASE_LSB +: 3] = tristate_phase_r;
				rd_mux[cssq_pkg::WRITE_PHASE_LSB +: 3]    = write_phase_r;
				rd_mux[cssq_pkg::LOCK_PHASE_LSB +: 3]     = lock_phase_r;
				rd_mux[cssq_pkg::MATCH_PHASE_LSB +: 3]    = match_phase_r;
				rd_mux[cssq_pkg::DONE_PIPE_BIT]           = done_pipelining_r;
				rd_mux[cssq_pkg::ACTIVE_RECONFIG_BIT]     = active_reconfig_option_r;
				rd_mux[cssq_pkg::PORT_SELECT_LSB +: 2]    = config_port_select_r;
				rd_mux[cssq_pkg::SECURITY_LSB +: 2]       = security_r;
				rd_mux[cssq_pkg::ERROR_SIGNAL_BIT]        = error_signal_r;
			end
			cssq_pkg::STATUS_OFFSET: begin
				rd_mux[0] = done_r;
				rd_mux[1] = !tristate_r;
				rd_mux[2] = write_en_r;
				rd_mux[3] = lock_hold;
				rd_mux[4] = match_hold;
				rd_mux[5] = error_r;
				rd_mux[6] = (state_r == cssq_pkg::CSSQ_END);
			end
			cssq_pkg::PHASE_OFFSET: begin
				rd_mux[2:0] = phase_r;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_read) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule

// *** verif/cssq_sequencer_assertions.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the startup sequencer
// ----------------------------------------
module cssq_sequencer_checker (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        config_clk,
	input wire logic        clock_manager_locked,
	input wire logic        impedance_calibration_match,
	input wire logic        load_done,
	input wire logic        config_error,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        done_out,
	input wire logic        global_output_tristate,
	input wire logic        global_write_enable,
	input wire logic        bram_enable,
	input wire logic        global_interconnect_hold,
	input wire logic        global_set_reset,
	input wire logic        port_upper_enable,
	input wire logic        port_lower_enable,
	input wire logic        readback_enable,
	input wire logic        init_status_n
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	logic [31:0] opt_r;
	logic        cc_r;
	logic        lk_seen_r;
	logic        mt_seen_r;
	logic [3:0]  tick_r;
	logic [2:0]  dn, ts, wp, lk, mt;
	logic        no_wait;

	// Field views of the shadowed option word.
	assign dn = opt_r[2:0];
	assign ts = opt_r[6:4];
	assign wp = opt_r[10:8];
	assign lk = opt_r[14:12];
	assign mt = opt_r[18:16];
	assign no_wait = (lk == 3'h7) && (mt == 3'h7);

	// Shadow of the option word, so expectations follow software writes.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			opt_r <= 32'h0407_7654;
		end else if (reg_write && (reg_addr == cssq_pkg::OPTIONS_OFFSET)) begin
			opt_r <= reg_wdata;
		end
	end

	// Raw link clock rises in this load, saturating.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cc_r <= 1'b0;
			tick_r <= 4'h0;
		end else begin
			cc_r <= config_clk;
			if (!load_done)
				tick_r <= 4'h0;
			else if (config_clk && !cc_r && (tick_r != 4'hF))
				tick_r <= tick_r + 4'h1;
		end
	end

	// Lock and match seen in the current load.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lk_seen_r <= 1'b0;
			mt_seen_r <= 1'b0;
		end else begin
			lk_seen_r <= load_done && (lk_seen_r || clock_manager_locked);
			mt_seen_r <= load_done && (mt_seen_r || impedance_calibration_match);
		end
	end

	property p_port_select;
		$past(rst_n) |-> (port_upper_enable == ($past(opt_r[23:22]) <= 2'h1)) &&
			(port_lower_enable == ($past(opt_r[23:22]) == 2'h2));
	endproperty
	a_port_select: assert property (p_port_select) else $error("access port enable wrong");
	property p_reconfig;
		$past(opt_r[21]) |-> !global_interconnect_hold && !global_set_reset;
	endproperty
	a_reconfig: assert property (p_reconfig) else $error("hold or set reset while reconfig");
	property p_readback;
		$past(rst_n) |-> readback_enable == ($past(opt_r[25:24]) == 2'h0);
	endproperty
	a_readback: assert property (p_readback) else $error("readback enable wrong");
	property p_done_phase;
		$rose(done_out) && no_wait && (dn inside {[3'h1:3'h6]}) |->
			tick_r == ({1'b0, dn} + 4'h1 + {3'h0, opt_r[20]});
	endproperty
	a_done_phase: assert property (p_done_phase) else $error("done in wrong phase");
	property p_tristate_phase;
		$fell(global_output_tristate) && no_wait && (ts inside {[3'h1:3'h6]}) |->
			tick_r == ({1'b0, ts} + 4'h1);
	endproperty
	a_tristate_phase: assert property (p_tristate_phase) else $error("tristate phase wrong");
	property p_write_phase;
		$rose(global_write_enable) && no_wait && (wp inside {[3'h1:3'h6]}) |->
			tick_r == ({1'b0, wp} + 4'h1);
	endproperty
	a_write_phase: assert property (p_write_phase) else $error("write enable phase wrong");
	property p_bram_gate;
		bram_enable == global_write_enable && (!$rose(bram_enable) || wp == 3'h0 || tick_r > wp);
	endproperty
	a_bram_gate: assert property (p_bram_gate) else $error("bram enable apart from write");
	property p_lock_wait;
		$rose(done_out) && (lk < dn) && (dn != 3'h7) |-> lk_seen_r;
	endproperty
	a_lock_wait: assert property (p_lock_wait) else $error("passed lock phase unlocked");
	property p_match_wait;
		$rose(done_out) && (mt < dn) && (dn != 3'h7) |-> mt_seen_r;
	endproperty
	a_match_wait: assert property (p_match_wait) else $error("passed match phase early");
	property p_error_init;
		config_error && opt_r[26] |-> ##[1:2] !init_status_n;
	endproperty
	a_error_init: assert property (p_error_init) else $error("init pin not driven low");

	c_done: cover property ($rose(done_out));
	c_lock_hold: cover property ($rose(clock_manager_locked) && load_done && !done_out);
	c_error: cover property ($fell(init_status_n));
endmodule

bind cssq_sequencer cssq_sequencer_checker cssq_sequencer_checker_inst (
	.core_clk(core_clk), .rst_n(rst_n), .config_clk(config_clk),
	.clock_manager_locked(clock_manager_locked),
	.impedance_calibration_match(impedance_calibration_match),
	.load_done(load_done), .config_error(config_error), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .done_out(done_out),
	.global_output_tristate(global_output_tristate), .global_write_enable(global_write_enable),
	.bram_enable(bram_enable), .global_interconnect_hold(global_interconnect_hold),
	.global_set_reset(global_set_reset), .port_upper_enable(port_upper_enable),
	.port_lower_enable(port_lower_enable), .readback_enable(readback_enable),
	.init_status_n(init_status_n)
);

// *** verif/cssq_config_source.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// External configuration clock source
// ----------------------------------------
module cssq_config_source (
	input  wire logic run,
	input  wire logic slow,
	output logic      config_clk
);
	// Clock stands low outside a load; the 3 ns offset keeps it off core edges.
	initial begin
		config_clk = 1'b0;
		#3;
		forever begin
			#(slow ? 60 : 40);
			if (run)
				config_clk = !config_clk;
			else
				config_clk = 1'b0;
		end
	end
endmodule

// *** verif/test_cssq_sequencer.sv ***
`timescale 1ns/1ps
module test_cssq_sequencer;
	logic        core_clk, rst_n, config_clk, load_done, config_error, reg_write, reg_read;
	logic        clock_manager_locked, impedance_calibration_match, run, slow;
	logic        done_out, global_output_tristate, global_write_enable, bram_enable;
	logic        global_interconnect_hold, global_set_reset, port_upper_enable;
	logic        port_lower_enable, readback_enable, init_status_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_val;
	int          fails, tests_run;

	cssq_sequencer cssq_sequencer_inst (
		.core_clk(core_clk), .rst_n(rst_n), .config_clk(config_clk), .load_done(load_done),
		.clock_manager_locked(clock_manager_locked), .config_error(config_error),
		.impedance_calibration_match(impedance_calibration_match), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .done_out(done_out), .bram_enable(bram_enable),
		.global_output_tristate(global_output_tristate), .global_set_reset(global_set_reset),
		.global_write_enable(global_write_enable), .port_upper_enable(port_upper_enable),
		.global_interconnect_hold(global_interconnect_hold), .init_status_n(init_status_n),
		.port_lower_enable(port_lower_enable), .readback_enable(readback_enable)
	);
	cssq_config_source cssq_config_source_inst (.run(run), .slow(slow), .config_clk(config_clk));

	// ----------------------------------------
	// Clock, bus tasks and bookkeeping
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic test_done();
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if ((fails == 0) && (tests_run > 0))
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic timeout();
		fails++;
		$display("CHECK FAILED t=%0t wait ran out", $time);
		test_done();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(cssq_pkg::OPTIONS_OFFSET);
		chk(rd_val, 32'h0407_7654);
		@(posedge core_clk);
		#1;
		chk(reg_rdata, 32'h0);
		wr(cssq_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
		rd(cssq_pkg::STATUS_OFFSET);
		chk(rd_val, 32'h0);
		rd(8'h0C);
		chk(rd_val, 32'h0);
		chk({done_out, global_output_tristate, global_write_enable, bram_enable,
			global_interconnect_hold, global_set_reset, port_upper_enable,
			port_lower_enable, readback_enable, init_status_n}, 10'b01_0011_1011);
	endtask
	task automatic t_options();
		for (int i = 0; i < 4; i++) begin
			wr(cssq_pkg::OPTIONS_OFFSET,
				32'h0407_7654 | (i << 22) | ((i % 3) << 24) | ((i % 2) << 21));
			cyc(2);
			#1;
			chk({port_upper_enable, port_lower_enable}, {i <= 1, i == 2});
			chk(readback_enable, (i % 3) == 0);
			chk({global_interconnect_hold, global_set_reset}, (i % 2) ? 2'b00 : 2'b11);
		end
		wr(cssq_pkg::OPTIONS_OFFSET, 32'h0407_7654);
	endtask
	// Runs one load for ten link ticks and notes the tick of each event; 0 means never.
	task automatic seq(input logic [31:0] o, input int ed, input int et, input int ew,
		input logic sl);
		int   tk = 0;
		int   td = 0;
		int   tt = 0;
		int   tw = 0;
		int   n;
		logic p;
		slow <= sl;
		wr(cssq_pkg::OPTIONS_OFFSET, o);
		load_done <= 1'b1;
		cyc(2);
		run <= 1'b1;
		p = config_clk;
		for (n = 0; (n < 800) && (tk < 10); n++) begin
			@(posedge core_clk);
			#1;
			if (config_clk && !p)
				tk++;
			p = config_clk;
			if ((done_out === 1'b1) && (td == 0))
				td = tk;
			if ((global_output_tristate === 1'b0) && (tt == 0))
				tt = tk;
			if ((global_write_enable === 1'b1) && (tw == 0))
				tw = tk;
		end
		if (n >= 800)
			timeout();
		chk(td, ed);
		chk(tt, et);
		chk(tw, ew);
		chk(bram_enable, ew != 0);
		rd(cssq_pkg::STATUS_OFFSET);
		chk(rd_val[6:0], {1'b1, 3'b000, ew != 0, et != 0, ed != 0});
		load_done <= 1'b0;
		run <= 1'b0;
		cyc(3);
		#1;
		chk({done_out, global_output_tristate, global_write_enable}, 3'b010);
	endtask
	// Sets the wait in phase 2, runs the load for eight link periods, then releases the awaited signal.
	task automatic t_wait(input int lsb, input int sb);
		int n;
		wr(cssq_pkg::OPTIONS_OFFSET, (32'h0407_7654 & ~(32'h7 << lsb)) | (32'h2 << lsb));
		load_done <= 1'b1;
		run <= 1'b1;
		cyc(80);
		rd(cssq_pkg::PHASE_OFFSET);
		chk(rd_val[2:0], 3'h2);
		rd(cssq_pkg::STATUS_OFFSET);
		chk({rd_val[sb], rd_val[0]}, 2'b10);
		if (lsb == cssq_pkg::LOCK_PHASE_LSB)
			clock_manager_locked <= 1'b1;
		else
			impedance_calibration_match <= 1'b1;
		for (n = 0; (n < 400) && (done_out !== 1'b1); n++)
			@(posedge core_clk);
		if (n >= 400)
			timeout();
		chk(done_out, 1'b1);
		load_done <= 1'b0;
		run <= 1'b0;
		clock_manager_locked <= 1'b0;
		impedance_calibration_match <= 1'b0;
		cyc(3);
	endtask
	task automatic t_error();
		config_error <= 1'b1;
		@(posedge core_clk);
		config_error <= 1'b0;
		cyc(2);
		#1;
		chk(init_status_n, 1'b0);
		load_done <= 1'b1;
		wr(cssq_pkg::OPTIONS_OFFSET, 32'h0007_7654);
		#1;
		chk(init_status_n, 1'b1);
		config_error <= 1'b1;
		@(posedge core_clk);
		config_error <= 1'b0;
		cyc(3);
		#1;
		chk(init_status_n, 1'b1);
		rd(cssq_pkg::STATUS_OFFSET);
		chk(rd_val[5], 1'b1);
		load_done <= 1'b0;
		wr(cssq_pkg::OPTIONS_OFFSET, 32'h0407_7654);
	endtask

	// Main sequence: reset, then each scenario in turn.
	initial begin
		rst_n = 1'b0;
		{load_done, config_error, reg_write, reg_read, run, slow} = 6'h00;
		{clock_manager_locked, impedance_calibration_match} = 2'b00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		fails = 0;
		tests_run = 0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_options();
		seq(32'h0407_7654, 5, 6, 7, 1'b0);
		seq(32'h0417_7001, 3, 3, 3, 1'b1);
		seq(32'h0407_7717, 0, 2, 0, 1'b0);
		seq(32'h0407_7160, 0, 7, 2, 1'b0);
		impedance_calibration_match <= 1'b1;
		seq(32'h0402_7674, 5, 0, 7, 1'b0);
		impedance_calibration_match <= 1'b0;
		t_wait(cssq_pkg::LOCK_PHASE_LSB, 3);
		t_wait(cssq_pkg::MATCH_PHASE_LSB, 4);
		t_error();
		test_done();
	end
endmodule
